/* File: design/irc_request_service_mask.sv */
// request, in-service, priority threshold and source mask state
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module irc_request_service_mask
  import irc_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // clock, reset, enable
  input  wire logic                        clock_in,
  input  wire logic                        resetn_in,
  input  wire logic                        clk_en_in,
  // mode straps
  input  wire logic                        slave_mode_in,
  input  wire logic                        fully_nested_in,
  // register port
  input  wire logic [ADDR_W-1:0]           reg_addr_in,
  input  wire logic [IRC_REG_W-1:0]        reg_wdata_in,
  input  wire logic                        reg_wr_in,
  input  wire logic                        reg_rd_in,
  output logic      [IRC_REG_W-1:0]        reg_rdata_out,
  // sources and their priorities
  input  wire irc_src_s                    src_req_in,
  input  wire logic [IRC_NSRC-1:0][2:0]    src_prio_in,
  // per-source control register mask bit
  input  wire logic [IRC_NSRC-1:0]         ctl_mask_wr_in,
  input  wire logic [IRC_NSRC-1:0]         ctl_mask_wdata_in,
  output logic      [IRC_NSRC-1:0]         source_mask_out,
  // core acknowledge and end of interrupt
  input  wire logic                        ack_in,
  input  wire logic [3:0]                  ack_bit_in,
  input  wire logic                        eoi_in,
  input  wire logic [3:0]                  eoi_bit_in,
  // gated requests toward the arbiter
  output logic      [IRC_NSRC-1:0]         irq_lines_out,
  output logic                             irq_any_out,
  output logic      [IRC_NSRC-1:0]         in_service_out
);

  if (ADDR_W < 6 || ADDR_W > 16) begin : g_chk
    $error("irc: ADDR_W must be 6..16");
  end

  localparam logic [ADDR_W-1:0] A_MASK = ADDR_W'(IRC_OFS_MASK);
  localparam logic [ADDR_W-1:0] A_PRIO = ADDR_W'(IRC_OFS_PRIO);
  localparam logic [ADDR_W-1:0] A_INS  = ADDR_W'(IRC_OFS_INS);
  localparam logic [ADDR_W-1:0] A_REQ  = ADDR_W'(IRC_OFS_REQ);

  irc_vec_t            pend_q;
  irc_vec_t            ins_q;
  irc_vec_t            mask_q;
  irc_vec_t            prev_s_q;
  irc_vec_t            lines_q;
  logic                any_q;
  logic [2:0]          thr_q;
  logic [IRC_REG_W-1:0] rdata_q;

  irc_vec_t valid;
  irc_vec_t raw_m;
  irc_vec_t raw_s;
  irc_vec_t rise_s;
  irc_vec_t ack_vec;
  irc_vec_t eoi_vec;
  irc_vec_t present;
  irc_vec_t allow_d;
  irc_vec_t mask_d;

  // unimplemented positions never hold state
  assign valid   = slave_mode_in ? IRC_VALID_SLAVE[IRC_NSRC-1:0]
                                 : IRC_VALID_MASTER[IRC_NSRC-1:0];
  assign raw_m   = irc_master_vec(src_req_in);
  assign raw_s   = irc_slave_vec(src_req_in);
  // slave requests count on their rising edge so a held line acks once
  assign rise_s  = raw_s & ~prev_s_q;
  assign ack_vec = ack_in ? (irc_onehot(ack_bit_in) & valid) : '0;
  assign eoi_vec = eoi_in ? (irc_onehot(eoi_bit_in) & valid) : '0;

  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      prev_s_q <= '0;
    end else if (clk_en_in) begin
      prev_s_q <= raw_s;
    end
  end

  // slave pending requests, set wins over acknowledge
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      pend_q <= IRC_REQ_RST[IRC_NSRC-1:0];
    end else if (clk_en_in) begin
      if (slave_mode_in) begin
        pend_q <= ((pend_q & ~ack_vec) | rise_s) & valid;
      end else begin
        pend_q <= '0;
      end
    end
  end

  // in-service flags
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      ins_q <= IRC_INS_RST[IRC_NSRC-1:0];
    end else if (clk_en_in) begin
      if (slave_mode_in) begin
        ins_q <= ((ins_q & ~(ack_vec | eoi_vec)) | rise_s) & valid;
      end else begin
        ins_q <= ((ins_q & ~eoi_vec) | ack_vec) & valid;
      end
    end
  end

  // one mask state shared by the bus copy and the control registers
  always_comb begin
    mask_d = mask_q;
    if (reg_wr_in && reg_addr_in == A_MASK) begin
      mask_d = reg_wdata_in[IRC_NSRC-1:0];
    end
    // control register write lands last when both hit one bit
    mask_d = (mask_d & ~ctl_mask_wr_in) | (ctl_mask_wdata_in & ctl_mask_wr_in);
    mask_d = mask_d & valid;
  end

  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      // mode strap is static, sampled by the synchronous reset
      mask_q <= slave_mode_in ? IRC_MASK_RST_SLAVE[IRC_NSRC-1:0]
                              : IRC_MASK_RST_MASTER[IRC_NSRC-1:0];
    end else if (clk_en_in) begin
      mask_q <= mask_d;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      thr_q <= IRC_PRIO_RST;
    end else if (clk_en_in) begin
      if (reg_wr_in && reg_addr_in == A_PRIO) begin
        thr_q <= reg_wdata_in[IRC_PRIO_W-1:0];
      end
    end
  end

  // request gating: mask, priority threshold, in-service block
  always_comb begin
    logic blocked;
    blocked = 1'b0;
    present = slave_mode_in ? pend_q : (raw_m & valid);
    allow_d = '0;
    for (int i = 0; i < IRC_NSRC; i++) begin
      blocked = !slave_mode_in && ins_q[i];
      if (fully_nested_in && (i == IRC_BIT_EXT0 || i == IRC_BIT_EXT1)) begin
        blocked = 1'b0;
      end
      // unsigned compare: threshold seven admits all
      allow_d[i] = present[i] && !mask_q[i] && (src_prio_in[i] <= thr_q)
                   && !blocked;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      lines_q <= '0;
      any_q   <= 1'b0;
    end else if (clk_en_in) begin
      lines_q <= allow_d;
      any_q   <= |allow_d;
    end
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      rdata_q <= '0;
    end else if (clk_en_in) begin
      rdata_q <= '0;
      if (reg_rd_in) begin
        unique case (reg_addr_in)
          A_MASK:  rdata_q <= {5'h0, mask_q};
          A_PRIO:  rdata_q <= {13'h0, thr_q};
          A_INS:   rdata_q <= {5'h0, ins_q};
          A_REQ:   rdata_q <= {5'h0, present};
          default: rdata_q <= '0;
        endcase
      end
    end
  end

  assign reg_rdata_out   = rdata_q;
  assign source_mask_out = mask_q;
  assign irq_lines_out   = lines_q;
  assign irq_any_out     = any_q;
  assign in_service_out  = ins_q;

endmodule
`default_nettype wire

/* File: shared/irc_pkg.sv */
// constants, types and helpers for the interrupt request/service/mask block
// Notes on behaviour
// - slave mode request register is read-only latched pending status
// - slave: internal request sets pending, acknowledge clears
// - slave request layout: t2 5, t1 4, dma 3:2, t0 0
// - slave request register resets to zero
// - master: in-service bit set when interrupt taken
// - end-of-interrupt clears the matching in-service bit
// - in-service source raises no new request in master mode; slave mode does not block it
// - fully nested mode exempts external 0 and 1
// - master in-service register resets to zero
// - master in-service layout: serial 10, wdog 9, ext 8:4
// - slave in-service read-only, timers and dma bits
// - slave in-service set on request, cleared on acknowledge
// - priority threshold field in bits 2 to 0
// - priority above threshold is suppressed, 0 highest
// - priority threshold resets to seven
// - threshold seven passes every unmasked source
// - mask register read/write, 1 masks, 0 enables
// - master mask layout matches in-service layout
// - master mask resets with all sources masked
// - slave mask bits mirror per-source control mask
// - slave mask resets with timers and dma masked
// - control-register mask bit and copy share state
// - master timer unit bit is OR of timers
package irc_pkg;

  localparam int          IRC_NSRC   = 11;
  localparam int          IRC_REG_W  = 16;
  localparam int          IRC_PRIO_W = 3;

  // register offsets
  localparam logic [15:0] IRC_OFS_MASK = 16'h0028;
  localparam logic [15:0] IRC_OFS_PRIO = 16'h002a;
  localparam logic [15:0] IRC_OFS_INS  = 16'h002c;
  localparam logic [15:0] IRC_OFS_REQ  = 16'h002e;

  // field positions
  localparam int IRC_BIT_TIMER_ZERO_BIT = 0;
  localparam int IRC_BIT_DMA0 = 2;
  localparam int IRC_BIT_DMA1 = 3;
  localparam int IRC_BIT_TIMER_ONE_BIT = 4;
  localparam int IRC_BIT_TIMER_TWO_BIT = 5;
  localparam int IRC_BIT_EXT0 = 4;
  localparam int IRC_BIT_EXT1 = 5;
  localparam int IRC_BIT_WDOG = 9;
  localparam int IRC_BIT_SER  = 10;

  // reset values and implemented-bit masks
  localparam logic [15:0] IRC_MASK_RST_MASTER = 16'h07fd;
  localparam logic [15:0] IRC_MASK_RST_SLAVE  = 16'h003d;
  localparam logic [15:0] IRC_VALID_MASTER    = 16'h07fd;
  localparam logic [15:0] IRC_VALID_SLAVE     = 16'h003d;
  localparam logic [2:0]  IRC_PRIO_RST        = 3'h7;
  localparam logic [15:0] IRC_INS_RST         = 16'h0000;
  localparam logic [15:0] IRC_REQ_RST         = 16'h0000;

  // raw source request lines
  typedef struct packed {
    logic       serial;
    logic       watchdog;
    logic [4:0] ext;
    logic [1:0] dma;
    logic [2:0] timer;
  } irc_src_s;

  typedef logic [IRC_NSRC-1:0] irc_vec_t;

  // master layout, timer unit is the OR of the three timers
  function automatic irc_vec_t irc_master_vec(irc_src_s s);
    irc_vec_t v;
    v = '0;
    v[IRC_BIT_SER]                  = s.serial;
    v[IRC_BIT_WDOG]                 = s.watchdog;
    v[8:4]                          = s.ext;
    v[IRC_BIT_DMA1:IRC_BIT_DMA0]    = s.dma;
    v[IRC_BIT_TIMER_ZERO_BIT]                 = |s.timer;
    return v;
  endfunction

  // slave layout, internal sources only
  function automatic irc_vec_t irc_slave_vec(irc_src_s s);
    irc_vec_t v;
    v = '0;
    v[IRC_BIT_TIMER_TWO_BIT]              = s.timer[2];
    v[IRC_BIT_TIMER_ONE_BIT]              = s.timer[1];
    v[IRC_BIT_DMA1:IRC_BIT_DMA0] = s.dma;
    v[IRC_BIT_TIMER_ZERO_BIT]              = s.timer[0];
    return v;
  endfunction

  function automatic irc_vec_t irc_onehot(logic [3:0] b);
    irc_vec_t v;
    v = '0;
    if (b < 4'(IRC_NSRC)) begin
      v[b] = 1'b1;
    end
    return v;
  endfunction

endpackage

/* File: testbench/irc_chk.sv */
// port assertions for the request, service and mask block
`timescale 1ns/1ps
`default_nettype none
module irc_chk
  import irc_pkg::*;
#(parameter int ADDR_W = 8) (
  // clock, reset, straps
  input wire logic                     clock_in,
  input wire logic                     resetn_in,
  input wire logic                     clk_en_in,
  input wire logic                     slave_mode_in,
  input wire logic                     fully_nested_in,
  // register port
  input wire logic [ADDR_W-1:0]        reg_addr_in,
  input wire logic [IRC_REG_W-1:0]     reg_wdata_in,
  input wire logic                     reg_wr_in,
  input wire logic                     reg_rd_in,
  input wire logic [IRC_REG_W-1:0]     reg_rdata_out,
  // sources, control masks, core
  input wire irc_src_s                 src_req_in,
  input wire logic [IRC_NSRC-1:0][2:0] src_prio_in,
  input wire logic [IRC_NSRC-1:0]      ctl_mask_wr_in,
  input wire logic [IRC_NSRC-1:0]      ctl_mask_wdata_in,
  input wire logic [IRC_NSRC-1:0]      source_mask_out,
  input wire logic                     ack_in,
  input wire logic [3:0]               ack_bit_in,
  input wire logic                     eoi_in,
  input wire logic [3:0]               eoi_bit_in,
  input wire logic [IRC_NSRC-1:0]      irq_lines_out,
  input wire logic                     irq_any_out,
  input wire logic [IRC_NSRC-1:0]      in_service_out
);
  logic [10:0] vld;
  logic [10:0] exm;
  assign vld = slave_mode_in ? IRC_VALID_SLAVE[10:0] : IRC_VALID_MASTER[10:0];
  assign exm = fully_nested_in ? 11'h030 : 11'h000;
  default clocking @(posedge clock_in); endclocking
  default disable iff (!resetn_in);
  sequence ack9_s;
    !slave_mode_in && clk_en_in && ack_in && ack_bit_in == 4'h9;
  endsequence
  rst_val_a: assert property (disable iff (1'b0) !resetn_in |=>
    in_service_out == '0 && irq_lines_out == '0 && source_mask_out == $past(vld))
    else $error("reset state wrong");
  mask_rsvd_a: assert property (clk_en_in && reg_rd_in && reg_addr_in == 8'h28 |=>
    (reg_rdata_out & ~{5'h00, vld}) == '0) else $error("mask reserved bits set");
  prio_rsvd_a: assert property (clk_en_in && reg_rd_in && reg_addr_in == 8'h2a |=>
    reg_rdata_out[15:3] == '0) else $error("threshold reserved bits set");
  mask_wr_a: assert property (clk_en_in && reg_wr_in && reg_addr_in == 8'h28 &&
    ctl_mask_wr_in == '0 |=> source_mask_out == $past(reg_wdata_in[10:0] & vld))
    else $error("mask write lost");
  ctl_wr_a: assert property (clk_en_in && |ctl_mask_wr_in && !reg_wr_in |=>
    (source_mask_out & $past(ctl_mask_wr_in & vld)) ==
    $past(ctl_mask_wdata_in & ctl_mask_wr_in & vld)) else $error("control mask not shared");
  mask_gate_a: assert property (clk_en_in |=>
    (irq_lines_out & $past(source_mask_out)) == '0) else $error("masked line raised");
  ins_block_a: assert property (!slave_mode_in && clk_en_in |=>
    (irq_lines_out & $past(in_service_out & ~exm)) == '0) else $error("in-service line raised");
  ack_set_a: assert property (ack9_s |=> in_service_out[9])
    else $error("ack did not set in-service");
  eoi_clr_a: assert property (!slave_mode_in && clk_en_in && eoi_in && eoi_bit_in == 4'h9 &&
    !(ack_in && ack_bit_in == 4'h9) |=> !in_service_out[9]) else $error("eoi did not clear");
  slave_set_a: assert property (slave_mode_in && clk_en_in && $rose(src_req_in.dma[0]) |=>
    in_service_out[2]) else $error("slave request did not set in-service");
endmodule
bind irc_request_service_mask irc_chk #(.ADDR_W(ADDR_W)) u_chk (.*);
`default_nettype wire

/* File: testbench/irc_core_model.sv */
// core model: takes one interrupt each time it is asked
`timescale 1ns/1ps
`default_nettype none
module irc_core_model
  import irc_pkg::*;
(
  // clock and request to take one
  input  wire logic                clock_in,
  input  wire logic                go_in,
  input  wire logic [IRC_NSRC-1:0] irq_lines_in,
  // acknowledge toward the block
  output var logic                 ack_out = 1'b0,
  output var logic [3:0]           ack_bit_out = 4'h0
);
  logic armed_q = 1'b0;
  // waits as long as no line is up, so it answers slowly too
  always @(posedge clock_in) begin : p_take
    int pick;
    pick = 0;
    // lowest raised line wins, picked before the single assignment below
    for (int i = IRC_NSRC - 1; i >= 0; i--) begin
      if (irq_lines_in[i]) begin
        pick = i;
      end
    end
    ack_out <= 1'b0;
    if (go_in) begin
      armed_q <= 1'b1;
    end else if (armed_q && |irq_lines_in) begin
      armed_q <= 1'b0;
      ack_out <= 1'b1;
      ack_bit_out <= 4'(pick);
    end
  end
endmodule
`default_nettype wire

/* File: testbench/irc_request_service_mask_bench.sv */
// self-checking bench for the request, service and mask block
`timescale 1ns/1ps
`default_nettype none
module irc_request_service_mask_bench
  import irc_pkg::*;
  ;
  logic             clk = 0, rstn = 0, slave = 0, nested = 0, wr = 0, rd = 0, end_of_interrupt_reg = 0, go = 0;
  logic             en = 1;
  logic             ack, any;
  logic [7:0]       addr = '0;
  logic [15:0]      wdata = '0, rdata, d;
  logic [3:0]       eoi_bit = '0, ack_bit;
  logic [10:0]      ctl_wr = '0, ctl_wd = '0, smask, lines, ins, raw, m;
  logic [10:0][2:0] prio = '0;
  irc_src_s         src = '0, s;
  int               err_total = 0, total_checks = 0, thr;
  irc_request_service_mask #(.ADDR_W(8)) u_irc_request_service_mask (
    .clock_in(clk), .resetn_in(rstn), .clk_en_in(en), .slave_mode_in(slave),
    .fully_nested_in(nested), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_rdata_out(rdata), .src_req_in(src), .src_prio_in(prio),
    .ctl_mask_wr_in(ctl_wr), .ctl_mask_wdata_in(ctl_wd), .source_mask_out(smask),
    .ack_in(ack), .ack_bit_in(ack_bit), .eoi_in(end_of_interrupt_reg), .eoi_bit_in(eoi_bit),
    .irq_lines_out(lines), .irq_any_out(any), .in_service_out(ins));
  irc_core_model u_irc_core_model (.clock_in(clk), .go_in(go), .irq_lines_in(lines),
    .ack_out(ack), .ack_bit_out(ack_bit));
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wrr(input logic [7:0] a, input logic [15:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask
  // code f arms the core model, any other code is a one-cycle end of interrupt
  task automatic take(input logic [3:0] b);
    @(posedge clk);
    if (b == 4'hf) begin
      go <= 1'b1;
    end else begin
      end_of_interrupt_reg <= 1'b1;
      eoi_bit <= b;
    end
    @(posedge clk);
    go <= 1'b0;
    end_of_interrupt_reg <= 1'b0;
    tick(4);
  endtask
  // expected gated lines in master mode, in-service idle
  function automatic logic [10:0] gate(input logic [10:0] r, input logic [10:0] mk, input int t);
    logic [10:0] g;
    for (int i = 0; i < 11; i++) g[i] = r[i] && !mk[i] && int'(prio[i]) <= t;
    return g;
  endfunction
  task automatic close_out;
    if (err_total == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #200000;
    err_total++;
    close_out;
  end
  initial begin
    void'($urandom(53039));
    tick(16);
    rstn <= 1'b1;
    rdc(8'h28, 16'h07fd);
    rdc(8'h2a, 16'h0007);
    rdc(8'h2c, 16'h0000);
    rdc(8'h30, 16'h0000);
    repeat (4) begin
      d = 16'($urandom);
      wrr(8'h28, d);
      rdc(8'h28, d & 16'h07fd);
      wrr(8'h2a, d);
      rdc(8'h2a, d & 16'h0007);
      wrr(8'h2c, d);
      rdc(8'h2c, 16'h0000);
    end
    // clock enable low: the write must not land
    en <= 1'b0;
    wrr(8'h28, 16'h0000);
    en <= 1'b1;
    rdc(8'h28, d & 16'h07fd);
    wrr(8'h28, 16'h0000);
    for (thr = 0; thr < 8; thr++) begin
      s = irc_src_s'(12'($urandom));
      src <= s;
      prio <= 33'({$urandom, $urandom});
      wrr(8'h2a, 16'(thr));
      tick(2);
      raw = {s.serial, s.watchdog, s.ext, s.dma, 1'b0, |s.timer};
      chk(16'(lines), 16'(gate(raw, '0, thr)));
      chk(16'(any), 16'(|gate(raw, '0, thr)));
    end
    m = 11'($urandom);
    wrr(8'h28, 16'(m));
    tick(2);
    chk(16'(lines), 16'(gate(raw, m & 11'h7fd, 7)));
    wrr(8'h28, 16'h0000);
    s = '0;
    s.watchdog = 1'b1;
    src <= s;
    nested <= 1'b1;
    take(4'hf);
    rdc(8'h2c, 16'h0200);
    chk(16'(lines), 16'h0000);
    take(4'h9);
    rdc(8'h2c, 16'h0000);
    s = '0;
    s.ext[0] = 1'b1;
    src <= s;
    take(4'hf);
    chk(16'(ins), 16'h0010);
    chk(16'(lines), 16'h0010);
    @(posedge clk);
    rstn <= 1'b0;
    slave <= 1'b1;
    src <= '0;
    tick(2);
    rstn <= 1'b1;
    rdc(8'h28, 16'h003d);
    rdc(8'h2e, 16'h0000);
    @(posedge clk);
    ctl_wr <= 11'h004;
    @(posedge clk);
    ctl_wr <= '0;
    rdc(8'h28, 16'h0039);
    chk(16'(smask), 16'h0039);
    s = '0;
    s.dma[0] = 1'b1;
    src <= s;
    tick(3);
    rdc(8'h2e, 16'h0004);
    rdc(8'h2c, 16'h0004);
    take(4'hf);
    rdc(8'h2e, 16'h0000);
    rdc(8'h2c, 16'h0000);
    close_out;
  end
endmodule
`default_nettype wire
